// [hdl/mcs_pkg.sv]
// Constants, codes and helpers for the modem command settings block.
// Assumes a 40 MHz hclk and a single AHB-Lite master.
package mcs_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int RETRAIN_MAX_S = 30;
  localparam int RETRAIN_CYC = RETRAIN_MAX_S * CLK_HZ;

  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_MS_MODE = 8'h04;
  localparam logic [7:0] A_MS_MIN = 8'h08;
  localparam logic [7:0] A_MS_MAX = 8'h0C;
  localparam logic [7:0] A_RESULT = 8'h10;
  localparam logic [7:0] A_SETTINGS = 8'h14;
  localparam logic [7:0] A_RESP0 = 8'h20;
  localparam logic [7:0] A_RESP1 = 8'h24;
  localparam logic [7:0] A_RESP2 = 8'h28;
  localparam logic [7:0] A_RESP3 = 8'h2C;

  localparam int CMD_ARG_LSB = 8;
  localparam int MS_AUTO_BIT = 8;
  localparam int MS_HAS_AUTO = 9;
  localparam int MS_HAS_MIN = 10;
  localparam int MS_HAS_MAX = 11;
  localparam int RES_KIND_LSB = 4;
  localparam int RES_OP_LSB = 8;
  localparam int RES_SEQ_LSB = 24;
  localparam int SET_RT_LSB = 4;
  localparam int SET_BRK_LSB = 8;
  localparam int SET_EC_LSB = 12;
  localparam int SET_LC_LSB = 16;
  localparam int CAP_AUTO_LSB = 16;

  localparam logic [7:0] OP_FACTORY = 8'h01;
  localparam logic [7:0] OP_CTS = 8'h02;
  localparam logic [7:0] OP_SHOW_CFG = 8'h03;
  localparam logic [7:0] OP_SHOW_STATS = 8'h04;
  localparam logic [7:0] OP_RETRAIN = 8'h05;
  localparam logic [7:0] OP_BREAK = 8'h06;
  localparam logic [7:0] OP_EC = 8'h07;
  localparam logic [7:0] OP_LCONV = 8'h08;
  localparam logic [7:0] OP_SET_MOD = 8'h09;
  localparam logic [7:0] OP_QRY_MOD = 8'h0A;
  localparam logic [7:0] OP_QRY_CAP = 8'h0B;
  localparam logic [7:0] OP_SEND_BRK = 8'h0C;

  localparam logic [1:0] RES_OK = 2'h1;
  localparam logic [1:0] RES_ERROR = 2'h2;
  localparam logic [1:0] RES_NO_CARRIER = 2'h3;
  localparam logic [2:0] KIND_CFG = 3'h1;
  localparam logic [2:0] KIND_STATS = 3'h2;
  localparam logic [2:0] KIND_MOD = 3'h3;
  localparam logic [2:0] KIND_CAP = 3'h4;

  localparam logic [1:0] RT_RETRAIN = 2'h1;
  localparam logic [1:0] RT_FALL = 2'h2;

  localparam logic DEF_CTS = 1'h0;
  localparam logic [1:0] DEF_RT = 2'h2;
  localparam logic [2:0] DEF_BRK = 3'h5;
  localparam logic [2:0] DEF_EC = 3'h3;
  localparam logic [1:0] DEF_LC = 2'h0;
  localparam logic [7:0] DEF_MOD = 8'h38;
  localparam logic DEF_AUTO = 1'h1;
  localparam logic [16:0] DEF_MIN = 17'h0012C;
  localparam logic [16:0] DEF_MAX = 17'h07080;

  localparam logic [7:0] MAX_CTS = 8'h01;
  localparam logic [7:0] MAX_RT = 8'h02;
  localparam logic [7:0] MAX_BRK = 8'h05;
  localparam logic [7:0] MAX_EC = 8'h05;
  localparam logic [7:0] MAX_LC = 8'h02;
  localparam logic [16:0] MINR_LO = 17'h0012C;
  localparam logic [16:0] MINR_HI = 17'h08340;
  localparam logic [16:0] MAXR_LO = 17'h0012C;
  localparam logic [16:0] MAXR_HI = 17'h0DAC0;
  localparam logic [1:0] CAP_AUTO = 2'h3;

  localparam int NMOD = 11;
  // V.21 V.22 V.22bis V.23 V.32 V.32bis V.34 V.90 56k Bell103 Bell212
  localparam logic [NMOD-1:0][7:0] MOD_CODES = {8'h45, 8'h40, 8'h38, 8'h0C,
    8'h0B, 8'h0A, 8'h09, 8'h03, 8'h02, 8'h01, 8'h00};
  localparam logic [10:0] CAP_MODS = 11'h7FF;

  function automatic logic [NMOD-1:0] mod_onehot(input logic [7:0] code);
    logic [NMOD-1:0] r;
    r = '0;
    for (int i = 0; i < NMOD; i++) begin
      r[i] = (code == MOD_CODES[i]);
    end
    return r;
  endfunction

  function automatic logic in_range(input logic [16:0] v, input logic [16:0] lo,
                                    input logic [16:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction
endpackage

// [hdl/mcs_brk_if.sv]
// Break events and break actions between the command core and break unit.
// Assumes both ends run on hclk.
`timescale 1ns/1ps
interface mcs_brk_if;
  logic [2:0] mode;
  logic dte_brk;
  logic rem_brk;
  logic send_brk;
  logic ec_link;
  logic flush;
  logic to_remote;
  logic to_dte;
  logic immed;
  logic in_order;
  logic online_cmd;
  modport core(output mode, dte_brk, rem_brk, send_brk, ec_link,
               input flush, to_remote, to_dte, immed, in_order, online_cmd);
  modport brk(input mode, dte_brk, rem_brk, send_brk, ec_link,
              output flush, to_remote, to_dte, immed, in_order, online_cmd);
endinterface

// [hdl/mcs_brk.sv]
// Break unit: turns break events into one-cycle action pulses.
// Assumes events are one-cycle pulses from hclk logic.
`timescale 1ns/1ps
module mcs_brk
  import mcs_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  mcs_brk_if.brk b
);
  typedef struct packed {
    logic flush;
    logic to_remote;
    logic to_dte;
    logic immed;
    logic in_order;
    logic online_cmd;
  } mcs_brk_s;

  mcs_brk_s s;
  mcs_brk_s n;

  // Only one event acts per cycle: terminal break wins, then command, then remote
  always_comb begin
    n = '0;
    if (b.dte_brk) begin
      unique case (b.mode)
        3'h1: begin
          n.flush = 1'b1;
          n.to_remote = 1'b1;
        end
        3'h3: begin
          n.immed = 1'b1;
          n.to_remote = 1'b1;
        end
        3'h5: begin
          n.in_order = 1'b1;
          n.to_remote = 1'b1;
        end
        default: n.online_cmd = 1'b1;
      endcase
    end else if (b.send_brk) begin
      n.to_remote = 1'b1;
      unique case (b.mode)
        3'h0, 3'h1: n.flush = 1'b1;
        3'h2, 3'h3: n.immed = 1'b1;
        default: n.in_order = 1'b1;
      endcase
    end else if (b.rem_brk && !b.ec_link) begin
      n.to_dte = 1'b1;
      unique case (b.mode)
        3'h0, 3'h1: n.flush = 1'b1;
        3'h2, 3'h3: n.immed = 1'b1;
        default: n.in_order = 1'b1;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign b.flush = s.flush;
  assign b.to_remote = s.to_remote;
  assign b.to_dte = s.to_dte;
  assign b.immed = s.immed;
  assign b.in_order = s.in_order;
  assign b.online_cmd = s.online_cmd;
endmodule

// [hdl/mcs_top.sv]
// Modem command settings core: AHB-Lite register slave, command execution,
// CTS control, retrain policy, error-correction and modulation selection.
// Assumes one master with no pipelined transfers; rts_pin is asynchronous.
//
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module mcs_top
  import mcs_pkg::*;
#(
  parameter int unsigned RETRAIN_CYCLES = RETRAIN_CYC
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rts_pin,
  input wire logic sync_mode,
  input wire logic flow_pause,
  input wire logic connected,
  input wire logic line_poor,
  input wire logic retrain_ok,
  input wire logic dte_brk,
  input wire logic rem_brk,
  input wire logic ec_link,
  input wire logic [7:0] stat_reason,
  input wire logic [15:0] stat_last_tx,
  input wire logic [15:0] stat_hi_tx,
  input wire logic [15:0] stat_last_rx,
  input wire logic [15:0] stat_hi_rx,
  input wire logic [7:0] stat_proto,
  input wire logic [7:0] stat_comp,
  input wire logic [7:0] stat_quality,
  output logic cts,
  output logic retrain_req,
  output logic retrain_abandon,
  output logic fallback_req,
  output logic fallforward_req,
  output logic ec_enable,
  output logic ec_try_lapm,
  output logic ec_try_alt,
  output logic ec_hangup,
  output logic [7:0] mod_code,
  output logic mod_auto,
  output logic mod_fixed,
  output logic [16:0] mod_min,
  output logic [16:0] mod_max,
  output logic [10:0] mod_sel,
  output logic brk_flush,
  output logic brk_to_remote,
  output logic brk_to_dte,
  output logic brk_immed,
  output logic brk_in_order,
  output logic brk_online_cmd
);
  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic rts_m;
    logic rts_s;
    logic cts;
    logic cts_opt;
    logic [1:0] rt_pol;
    logic [2:0] brk;
    logic [2:0] ec;
    logic [1:0] lconv;
    logic [7:0] mod;
    logic auto;
    logic [16:0] rmin;
    logic [16:0] rmax;
    logic [11:0] arg_mode;
    logic [16:0] arg_min;
    logic [16:0] arg_max;
    logic [1:0] result;
    logic [2:0] kind;
    logic [7:0] last_op;
    logic [7:0] seq;
    logic [3:0][31:0] resp;
    logic send_brk;
    logic rt_active;
    logic [30:0] rt_cnt;
    logic rt_abandon;
    logic fb;
    logic ff;
    logic poor_d;
    logic ec_en;
    logic ec_lapm;
    logic ec_alt;
    logic ec_hang;
    logic [10:0] mod_sel;
  } mcs_top_s;

  mcs_top_s s;
  mcs_top_s n;
  mcs_brk_if bi();

  function automatic logic [31:0] settings_word(input mcs_top_s t);
    logic [31:0] w;
    w = '0;
    w[0] = t.cts_opt;
    w[SET_RT_LSB +: 2] = t.rt_pol;
    w[SET_BRK_LSB +: 3] = t.brk;
    w[SET_EC_LSB +: 3] = t.ec;
    w[SET_LC_LSB +: 2] = t.lconv;
    return w;
  endfunction

  function automatic logic [31:0] mod_word(input mcs_top_s t);
    logic [31:0] w;
    w = '0;
    w[7:0] = t.mod;
    w[MS_AUTO_BIT] = t.auto;
    return w;
  endfunction

  always_comb begin
    logic [7:0] op;
    logic [7:0] arg;
    logic [7:0] nm;
    logic na;
    logic [16:0] nmin;
    logic [16:0] nmax;
    logic ok;
    op = hwdata[7:0];
    arg = hwdata[CMD_ARG_LSB +: 8];
    nm = s.arg_mode[7:0];
    na = s.arg_mode[MS_HAS_AUTO] ? s.arg_mode[MS_AUTO_BIT] : s.auto;
    nmin = s.arg_mode[MS_HAS_MIN] ? s.arg_min : s.rmin;
    nmax = s.arg_mode[MS_HAS_MAX] ? s.arg_max : s.rmax;
    ok = 1'b0;
    n = s;
    n.hreadyout = 1'b1;
    n.hresp = 1'b0;
    n.send_brk = 1'b0;

    // Synchroniser for the RTS pin
    n.rts_m = rts_pin;
    n.rts_s = s.rts_m;

    // Address phase: read data is fetched now so the data phase needs no wait
    n.wr_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      n.wr_pend = hwrite;
      n.wr_addr = haddr[7:0];
      n.hrdata = '0;
      if (!hwrite) begin
        unique case (haddr[7:0])
          A_MS_MODE: n.hrdata = {20'h00000, s.arg_mode};
          A_MS_MIN: n.hrdata = {15'h0000, s.arg_min};
          A_MS_MAX: n.hrdata = {15'h0000, s.arg_max};
          A_RESULT: begin
            n.hrdata[1:0] = s.result;
            n.hrdata[RES_KIND_LSB +: 3] = s.kind;
            n.hrdata[RES_OP_LSB +: 8] = s.last_op;
            n.hrdata[RES_SEQ_LSB +: 8] = s.seq;
          end
          A_SETTINGS: n.hrdata = settings_word(s);
          A_RESP0: n.hrdata = s.resp[0];
          A_RESP1: n.hrdata = s.resp[1];
          A_RESP2: n.hrdata = s.resp[2];
          A_RESP3: n.hrdata = s.resp[3];
          default: n.hrdata = '0;
        endcase
      end
    end

    // Data phase of a write
    if (s.wr_pend) begin
      unique case (s.wr_addr)
        A_MS_MODE: n.arg_mode = hwdata[11:0];
        A_MS_MIN: n.arg_min = hwdata[16:0];
        A_MS_MAX: n.arg_max = hwdata[16:0];
        A_CMD: begin
          n.last_op = op;
          n.seq = s.seq + 8'h01;
          n.result = RES_ERROR;
          n.kind = '0;
          unique case (op)
            OP_FACTORY: begin
              if (!connected) begin
                n.cts_opt = DEF_CTS;
                n.rt_pol = DEF_RT;
                n.brk = DEF_BRK;
                n.ec = DEF_EC;
                n.lconv = DEF_LC;
                n.mod = DEF_MOD;
                n.auto = DEF_AUTO;
                n.rmin = DEF_MIN;
                n.rmax = DEF_MAX;
                n.result = RES_OK;
              end
            end
            OP_CTS: begin
              if (arg <= MAX_CTS) begin
                n.cts_opt = arg[0];
                n.result = RES_OK;
              end
            end
            OP_RETRAIN: begin
              if (arg <= MAX_RT) begin
                n.rt_pol = arg[1:0];
                n.result = RES_OK;
              end
            end
            OP_BREAK: begin
              if (arg <= MAX_BRK) begin
                n.brk = arg[2:0];
                n.result = RES_OK;
              end
            end
            OP_EC: begin
              if (arg <= MAX_EC) begin
                n.ec = arg[2:0];
                n.result = RES_OK;
              end
            end
            OP_LCONV: begin
              if (arg <= MAX_LC) begin
                n.lconv = arg[1:0];
                n.result = RES_OK;
              end
            end
            OP_SHOW_CFG: begin
              n.resp[0] = settings_word(s);
              n.resp[1] = mod_word(s);
              n.resp[2] = {15'h0000, s.rmin};
              n.resp[3] = {15'h0000, s.rmax};
              n.kind = KIND_CFG;
              n.result = RES_OK;
            end
            OP_SHOW_STATS: begin
              n.resp[0] = {stat_reason, stat_proto, stat_comp, stat_quality};
              n.resp[1] = {stat_hi_tx, stat_last_tx};
              n.resp[2] = {stat_hi_rx, stat_last_rx};
              n.resp[3] = '0;
              n.kind = KIND_STATS;
              n.result = RES_OK;
            end
            OP_SET_MOD: begin
              ok = (|mod_onehot(nm)) && in_range(nmin, MINR_LO, MINR_HI)
                && in_range(nmax, MAXR_LO, MAXR_HI) && (nmin <= nmax);
              if (ok) begin
                n.mod = nm;
                n.auto = na;
                n.rmin = nmin;
                n.rmax = nmax;
                n.result = RES_OK;
              end
            end
            OP_QRY_MOD: begin
              n.resp[0] = {24'h000000, s.mod};
              n.resp[1] = {31'h00000000, s.auto};
              n.resp[2] = {15'h0000, s.rmin};
              n.resp[3] = {15'h0000, s.rmax};
              n.kind = KIND_MOD;
              n.result = RES_OK;
            end
            OP_QRY_CAP: begin
              n.resp[0] = {21'h000000, CAP_MODS};
              n.resp[1] = {30'h00000000, CAP_AUTO};
              n.resp[2] = {MINR_HI[15:0], MINR_LO[15:0]};
              n.resp[3] = {MAXR_HI[15:0], MAXR_LO[15:0]};
              n.kind = KIND_CAP;
              n.result = RES_OK;
            end
            OP_SEND_BRK: begin
              if (connected) begin
                n.send_brk = 1'b1;
                n.result = RES_OK;
              end else begin
                n.result = RES_NO_CARRIER;
              end
            end
            default: n.result = RES_ERROR;
          endcase
        end
        default: n.arg_mode = s.arg_mode;
      endcase
    end

    // CTS handling
    if (sync_mode) begin
      n.cts = (s.cts_opt == DEF_CTS) ? s.rts_s : 1'b1;
    end else begin
      n.cts = !flow_pause;
    end

    // Retrain policy
    n.rt_abandon = 1'b0;
    n.fb = 1'b0;
    n.ff = 1'b0;
    n.poor_d = line_poor;
    if (s.rt_pol == RT_RETRAIN && connected) begin
      if (!s.rt_active) begin
        n.rt_active = line_poor;
        n.rt_cnt = '0;
      end else if (retrain_ok) begin
        n.rt_active = 1'b0;
      end else if (s.rt_cnt == 31'(RETRAIN_CYCLES - 1)) begin
        n.rt_active = 1'b0;
        n.rt_abandon = 1'b1;
      end else begin
        n.rt_cnt = s.rt_cnt + 31'h00000001;
      end
    end else begin
      n.rt_active = 1'b0;
      n.rt_cnt = '0;
    end
    if (s.rt_pol == RT_FALL && connected) begin
      n.fb = line_poor && !s.poor_d;
      n.ff = !line_poor && s.poor_d;
    end

    // Error-correction preference for the next connection
    n.ec_en = 1'b0;
    n.ec_lapm = 1'b0;
    n.ec_alt = 1'b0;
    n.ec_hang = 1'b0;
    unique case (n.ec)
      3'h2: begin
        n.ec_en = 1'b1;
        n.ec_lapm = 1'b1;
        n.ec_alt = 1'b1;
        n.ec_hang = 1'b1;
      end
      3'h3: begin
        n.ec_en = 1'b1;
        n.ec_lapm = 1'b1;
        n.ec_alt = 1'b1;
      end
      3'h4: begin
        n.ec_en = 1'b1;
        n.ec_lapm = 1'b1;
        n.ec_alt = (n.lconv != DEF_LC);
        n.ec_hang = 1'b1;
      end
      3'h5: begin
        n.ec_en = 1'b1;
        n.ec_alt = 1'b1;
        n.ec_hang = 1'b1;
      end
      default: n.ec_en = 1'b0;
    endcase

    n.mod_sel = mod_onehot(n.mod);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.hreadyout <= 1'b1;
      s.cts_opt <= DEF_CTS;
      s.rt_pol <= DEF_RT;
      s.brk <= DEF_BRK;
      s.ec <= DEF_EC;
      s.lconv <= DEF_LC;
      s.mod <= DEF_MOD;
      s.auto <= DEF_AUTO;
      s.rmin <= DEF_MIN;
      s.rmax <= DEF_MAX;
    end else begin
      s <= n;
    end
  end

  assign bi.mode = s.brk;
  assign bi.dte_brk = dte_brk;
  assign bi.rem_brk = rem_brk;
  assign bi.send_brk = s.send_brk;
  assign bi.ec_link = ec_link;

  mcs_brk u_brk (
    .hclk(hclk),
    .hresetn(hresetn),
    .b(bi.brk)
  );

  assign hreadyout = s.hreadyout;
  assign hresp = s.hresp;
  assign hrdata = s.hrdata;
  assign cts = s.cts;
  assign retrain_req = s.rt_active;
  assign retrain_abandon = s.rt_abandon;
  assign fallback_req = s.fb;
  assign fallforward_req = s.ff;
  assign ec_enable = s.ec_en;
  assign ec_try_lapm = s.ec_lapm;
  assign ec_try_alt = s.ec_alt;
  assign ec_hangup = s.ec_hang;
  assign mod_code = s.mod;
  assign mod_auto = s.auto;
  assign mod_fixed = !s.auto;
  assign mod_min = s.rmin;
  assign mod_max = s.rmax;
  assign mod_sel = s.mod_sel;
  assign brk_flush = bi.flush;
  assign brk_to_remote = bi.to_remote;
  assign brk_to_dte = bi.to_dte;
  assign brk_immed = bi.immed;
  assign brk_in_order = bi.in_order;
  assign brk_online_cmd = bi.online_cmd;
endmodule

// [dv/mcs_props.sv]
// Checker for mcs_top, watching its ports only.
// Assumes hclk domain only; bound from the testbench top.
`timescale 1ns/1ps
module mcs_props #(
  parameter int unsigned RETRAIN_CYCLES = 20
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic cts,
  input wire logic sync_mode,
  input wire logic flow_pause,
  input wire logic retrain_req,
  input wire logic retrain_abandon,
  input wire logic fallback_req,
  input wire logic fallforward_req,
  input wire logic ec_enable,
  input wire logic ec_try_lapm,
  input wire logic ec_try_alt,
  input wire logic ec_hangup,
  input wire logic mod_auto,
  input wire logic mod_fixed,
  input wire logic [16:0] mod_min,
  input wire logic [16:0] mod_max,
  input wire logic [10:0] mod_sel,
  input wire logic brk_to_remote,
  input wire logic brk_to_dte,
  input wire logic brk_online_cmd
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [31:0] rcnt;
  // Length of the current retrain run
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rcnt <= '0;
    end else begin
      rcnt <= retrain_req ? rcnt + 32'h1 : '0;
    end
  end
  a_bus_zero_wait: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_cts_async: assert property ($past(hresetn) && !$past(sync_mode) |->
    cts == !$past(flow_pause)) else $error("cts does not follow flow pause");
  a_retrain_bound: assert property (rcnt <= RETRAIN_CYCLES + 1)
    else $error("retrain ran too long");
  a_abandon_ends: assert property (retrain_abandon |-> !retrain_req)
    else $error("retrain kept after abandon");
  a_fall_pulse: assert property (fallback_req |=> !fallback_req && !fallforward_req)
    else $error("fallback not a pulse");
  a_ec_plain: assert property (!ec_enable |-> !ec_try_lapm && !ec_try_alt && !ec_hangup)
    else $error("protocol tried with correction off");
  a_mode_fixed: assert property (mod_fixed == !mod_auto) else $error("fixed not inverse of auto");
  a_sel_onehot: assert property ($past(hresetn) |-> $onehot(mod_sel))
    else $error("modulation select not one hot");
  a_rate_order: assert property (mod_min <= mod_max && mod_min >= 17'h0012C)
    else $error("rate limits out of order");
  a_brk_route: assert property (brk_online_cmd |-> !brk_to_remote && !brk_to_dte)
    else $error("break forwarded in command entry");
endmodule

// [dv/mcs_host.sv]
// Terminal-side model: issues commands as single AHB-Lite word transfers.
// Assumes one zero-or-more wait slave on hclk.
`timescale 1ns/1ps
module mcs_host (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Called right after a rising edge; returns at the data-phase edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  // Result is read back before the next command may go out
  task automatic cmd(input logic [7:0] op, input logic [7:0] arg, output logic [1:0] res);
    logic [31:0] r;
    xfer(1'b1, 8'h00, {16'h0, arg, op}, r);
    xfer(1'b0, 8'h10, 32'h0, r);
    res = r[1:0];
  endtask
endmodule

// [dv/mcs_top_tb.sv]
// Self-checking bench for mcs_top with the terminal model on its bus.
// Assumes a short retrain limit of 20 cycles.
`timescale 1ns/1ps
module mcs_top_tb;
  logic hclk = 0, hresetn = 0, hsel, hwrite, hreadyout, hresp, clr = 0;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans, res;
  logic [2:0] hsize;
  logic rts_pin = 0, sync_mode = 0, flow_pause = 0, connected = 0, line_poor = 0;
  logic retrain_ok = 0, dte_brk = 0, rem_brk = 0, ec_link = 0;
  logic cts, retrain_req, retrain_abandon, fallback_req, fallforward_req;
  logic ec_enable, ec_try_lapm, ec_try_alt, ec_hangup, mod_auto, mod_fixed;
  logic brk_flush, brk_to_remote, brk_to_dte, brk_immed, brk_in_order, brk_online_cmd;
  logic [7:0] mod_code, acc;
  logic [16:0] mod_min, mod_max;
  logic [10:0] mod_sel;
  logic [7:0] stat_reason, stat_proto, stat_comp, stat_quality;
  logic [15:0] stat_last_tx, stat_hi_tx, stat_last_rx, stat_hi_rx;
  int err_count = 0, checked = 0, cyc = 0;
  localparam logic [7:0] CODES [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h09, 8'h0A, 8'h0B,
    8'h0C, 8'h38, 8'h40, 8'h45};
  localparam logic [7:0] OPS [5] = '{8'h02, 8'h05, 8'h06, 8'h07, 8'h08};
  localparam logic [7:0] TOPS [5] = '{8'h01, 8'h02, 8'h05, 8'h05, 8'h02};
  initial forever #12.5 hclk = ~hclk;
  mcs_host mcs_host_i (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  mcs_top #(.RETRAIN_CYCLES(20)) mcs_top_i (.hready(hreadyout), .*);
  // Collects pulses so that short ones cannot slip between samples
  always @(posedge hclk) begin
    acc <= clr ? 8'h0 : acc | {retrain_abandon, fallback_req, brk_flush, brk_to_remote,
      brk_to_dte, brk_immed, brk_in_order, brk_online_cmd};
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    mcs_host_i.xfer(1'b0, a, 32'h0, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    mcs_host_i.xfer(1'b1, a, d, r);
  endtask
  task automatic clrp();
    clr <= 1;
    @(posedge hclk);
    clr <= 0;
  endtask
  task automatic pulse(input logic rem);
    if (rem) begin
      rem_brk <= 1;
    end else begin
      dte_brk <= 1;
    end
    @(posedge hclk);
    dte_brk <= 0;
    rem_brk <= 0;
    repeat (3) @(posedge hclk);
  endtask
  task automatic t_cfg();
    {stat_reason, stat_proto, stat_comp, stat_quality} <= 32'h11223344;
    {stat_hi_tx, stat_last_tx, stat_hi_rx, stat_last_rx} <= 64'h77885566BBCC99AA;
    mcs_host_i.cmd(8'h03, 8'h0, res);
    chk(res, 2'h1);
    rd(8'h20);
    chk(r, 32'h3520);
    rd(8'h24);
    chk(r, 32'h138);
    rd(8'h2C);
    chk(r, 32'h7080);
    mcs_host_i.cmd(8'h04, 8'h0, res);
    rd(8'h20);
    chk(r, 32'h11223344);
    rd(8'h24);
    chk(r, 32'h77885566);
    rd(8'h28);
    chk(r, 32'hBBCC99AA);
    $display("config and statistics done");
  endtask
  task automatic t_range();
    for (int i = 0; i < 5; i++) begin
      mcs_host_i.cmd(OPS[i], TOPS[i] + 8'h1, res);
      chk(res, 2'h2);
      mcs_host_i.cmd(OPS[i], TOPS[i], res);
      chk(res, 2'h1);
    end
    connected <= 1;
    mcs_host_i.cmd(8'h01, 8'h0, res);
    chk(res, 2'h2);
    connected <= 0;
    mcs_host_i.cmd(8'h01, 8'h0, res);
    chk(res, 2'h1);
    rd(8'h14);
    chk(r, 32'h3520);
    $display("range and factory done");
  endtask
  task automatic t_cts();
    sync_mode <= 1;
    for (int i = 0; i < 2; i++) begin
      rts_pin <= i[0];
      repeat (4) @(posedge hclk);
      chk(cts, i[0]);
    end
    rts_pin <= 0;
    mcs_host_i.cmd(8'h02, 8'h1, res);
    repeat (4) @(posedge hclk);
    chk(cts, 1'b1);
    sync_mode <= 0;
    flow_pause <= 1;
    repeat (3) @(posedge hclk);
    chk(cts, 1'b0);
    flow_pause <= 0;
    $display("cts done");
  endtask
  task automatic t_ec();
    for (int i = 0; i < 6; i++) begin
      mcs_host_i.cmd(8'h07, i[7:0], res);
      @(posedge hclk);
      chk({ec_enable, ec_try_lapm, ec_try_alt, ec_hangup},
          i < 2 ? 4'h0 : i == 2 ? 4'hF : i == 3 ? 4'hE : i == 4 ? 4'hD : 4'hB);
    end
    mcs_host_i.cmd(8'h08, 8'h1, res);
    mcs_host_i.cmd(8'h07, 8'h4, res);
    chk({ec_enable, ec_try_lapm, ec_try_alt, ec_hangup}, 4'hF);
    $display("error correction done");
  endtask
  task automatic t_brk();
    logic [5:0] e;
    mcs_host_i.cmd(8'h0C, 8'h0, res);
    chk(res, 2'h3);
    connected <= 1;
    for (int m = 0; m < 6; m++) begin
      e = m < 2 ? 6'h30 : m < 4 ? 6'h14 : 6'h12;
      mcs_host_i.cmd(8'h06, m[7:0], res);
      clrp();
      pulse(1'b0);
      chk(acc[5:0], m == 1 ? 6'h30 : m == 3 ? 6'h14 : m == 5 ? 6'h12 : 6'h01);
      clrp();
      mcs_host_i.cmd(8'h0C, 8'h0, res);
      repeat (2) @(posedge hclk);
      chk(acc[5:0], e);
      ec_link <= m[0];
      clrp();
      pulse(1'b1);
      chk(acc[5:0], m[0] ? 6'h00 : e ^ 6'h18);
    end
    $display("break done");
  endtask
  task automatic t_retrain();
    clrp();
    line_poor <= 1;
    repeat (4) @(posedge hclk);
    chk(acc[6], 1'b1);
    line_poor <= 0;
    repeat (2) @(posedge hclk);
    chk(fallforward_req, 1'b1);
    mcs_host_i.cmd(8'h05, 8'h1, res);
    clrp();
    line_poor <= 1;
    repeat (3) @(posedge hclk);
    chk(retrain_req, 1'b1);
    line_poor <= 0;
    repeat (25) @(posedge hclk);
    chk({acc[7], retrain_req}, 2'h2);
    connected <= 0;
    $display("retrain done");
  endtask
  task automatic t_mod();
    wr(8'h04, 32'h20A);
    mcs_host_i.cmd(8'h09, 8'h0, res);
    chk({res, mod_code, mod_auto, mod_fixed, mod_sel}, {2'h1, 8'h0A, 2'h1, 11'h020});
    chk(mod_min, 17'h0012C);
    chk(mod_max, 17'h07080);
    wr(8'h04, 32'h004);
    wr(8'h08, 32'h8340);
    wr(8'h0C, 32'h12C);
    mcs_host_i.cmd(8'h09, 8'h0, res);
    chk({res, mod_code}, {2'h2, 8'h0A});
    mcs_host_i.cmd(8'h0A, 8'h0, res);
    for (int i = 0; i < 4; i++) begin
      rd(8'h20 + 8'(4 * i));
      chk(r, i == 0 ? 32'hA : i == 1 ? 32'h0 : i == 2 ? 32'h12C : 32'h7080);
    end
    mcs_host_i.cmd(8'h0B, 8'h0, res);
    for (int i = 0; i < 4; i++) begin
      rd(8'h20 + 8'(4 * i));
      chk(r, i == 0 ? 32'h7FF : i == 1 ? 32'h3 : i == 2 ? 32'h8340012C : 32'hDAC0012C);
    end
    for (int i = 0; i < 11; i++) begin
      wr(8'h04, {24'h0, CODES[i]});
      mcs_host_i.cmd(8'h09, 8'h0, res);
      chk(mod_sel, 11'h1 << i);
    end
    $display("modulation done");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    t_cfg();
    t_range();
    t_cts();
    t_ec();
    t_brk();
    t_retrain();
    t_mod();
    complete_run();
  end
endmodule
bind mcs_top mcs_props #(.RETRAIN_CYCLES(RETRAIN_CYCLES)) mcs_props_i (.*);
